/* File: common/dma_act_map.svh */
// register offsets, field positions, reset values and select codes of the dma block
// assumes one channel occupies a 16-byte window on the register bus
`ifndef DMA_ACT_MAP_SVH
`define DMA_ACT_MAP_SVH

// word offsets inside one channel window
`define OFS_CTRL        4'h0
`define OFS_MEM         4'h4
`define OFS_PER         4'h8
`define OFS_CNT         4'hc

// control register fields
`define CTL_EN          7
`define CTL_WORD        6
`define CTL_DEC         5
`define CTL_INC         4
`define CTL_IRQ         3
`define CTL_MODE_HI     2
`define CTL_MODE_LO     1
`define CTL_BLOCK       0
`define CTL_SEL_HI      10
`define CTL_SEL_LO      8

// reset values
`define RST_CTRL        12'h000
`define RST_MEM         24'h000000
`define RST_PER         8'h00
`define RST_CNT         16'h0000

// fixed upper bits of a peripheral address
`define PER_HIGH        16'hffff

// activation select codes
`define SEL_AUTO_BURST  3'h0
`define SEL_AUTO_STEAL  3'h2
`define SEL_TX_EMPTY    3'h4
`define SEL_RX_FULL     3'h5
`define SEL_PIN_FALL    3'h6
`define SEL_PIN_LOW     3'h7

`endif

/* File: common/dma_act_pkg.sv */
// types shared by the dma channel activation design
// assumes the map header supplies the register constants; the mode and state encodings are defined here
package dma_act_pkg;

  typedef enum logic [1:0] {
    MODE_IO     = 2'b00,
    MODE_IDLE   = 2'b01,
    MODE_REPEAT = 2'b10,
    MODE_FULL   = 2'b11
  } chan_mode_e;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_XFER = 2'b01,
    ENG_NEXT = 2'b10
  } eng_state_e;

endpackage

/* File: verilog/req_pin_sync.sv */
// three-stage synchroniser for the active-low request pins, with falling edge pulse
// assumes pins are asynchronous to clk_i and idle high
`timescale 1ns/1ps
module req_pin_sync #(
  parameter int N = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [N-1:0] pin_n_i,
  output logic      [N-1:0] low_o,
  output logic      [N-1:0] fall_o
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] lvl;
    logic [N-1:0] fall;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  // level follows only once stages two and three agree
  always_comb
  begin
    st_next      = st_reg;
    st_next.s1   = pin_n_i;
    st_next.s2   = st_reg.s1;
    st_next.s3   = st_reg.s2;
    st_next.fall = st_reg.lvl & ~st_reg.s2 & ~st_reg.s3;
    st_next.lvl  = (st_reg.s2 & st_reg.s3) | (st_reg.lvl & (st_reg.s2 | st_reg.s3));
  end

  // state register with clock enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_reg <= '{s1: '1, s2: '1, s3: '1, lvl: '1, fall: '0};
    else if (ce_i)
      st_reg <= st_next;
  end

  assign low_o  = ~st_reg.lvl;
  assign fall_o = st_reg.fall;

endmodule // req_pin_sync

/* File: verilog/dma_act_ctrl.sv */
// dma channel activation and transfer sequencing with a wishbone register slave
// assumes one clock, an external arbiter answering xfer_req_o with xfer_ack_i
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "dma_act_map.svh"

module dma_act_ctrl #(
  parameter int NCH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic [3:0]       timer_event_i,
  input  wire logic             serial_tx_empty_i,
  input  wire logic             serial_rx_full_i,
  input  wire logic [NCH/2-1:0] dma_request_pin_n_i,
  output logic                  xfer_req_o,
  input  wire logic             xfer_ack_i,
  output logic      [23:0]      xfer_src_o,
  output logic      [23:0]      xfer_dst_o,
  output logic                  xfer_word_o,
  output logic                  bus_lock_o,
  output logic      [NCH-1:0]   end_pulse_o
);

  localparam int NP = NCH / 2;
  localparam int CW = $clog2(NCH);

  typedef struct packed {
    logic [NCH-1:0][11:0]    ctrl;
    logic [NCH-1:0][23:0]    mem;
    logic [NCH-1:0][23:0]    mem_init;
    logic [NCH-1:0][7:0]     per;
    logic [NCH-1:0][15:0]    cnt;
    logic [NCH-1:0][15:0]    cnt_init;
    logic [NCH-1:0]          pend;
    logic [NCH-1:0]          done;
    dma_act_pkg::eng_state_e state;
    logic [CW-1:0]           cur;
    logic                    xreq;
    logic [23:0]             src;
    logic [23:0]             dst;
    logic                    word;
    logic                    ack;
    logic [31:0]             dat;
  } dma_s;

  dma_s st_reg;
  dma_s st_next;

  logic [NP-1:0]        pin_low;
  logic [NP-1:0]        pin_fall;
  logic [NCH-1:0]       ev;
  logic [NCH-1:0]       ready;
  logic [NCH-1:0]       burst;
  logic [NCH-1:0]       is_full;
  logic [NCH-1:0][23:0] path_src;
  logic [NCH-1:0][23:0] path_dst;

  // request pins cross into the clock domain here
  req_pin_sync #(
    .N (NP)
  ) u_pin (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .pin_n_i (dma_request_pin_n_i),
    .low_o   (pin_low),
    .fall_o  (pin_fall)
  );

  // address step by one unit, up or down, or held
  function automatic logic [23:0] step(input logic [23:0] a, input logic [11:0] c,
                                       input logic word);
    logic [23:0] d;
    d = word ? 24'h000002 : 24'h000001;
    if (!c[`CTL_INC])
      step = a;
    else if (c[`CTL_DEC])
      step = a - d;
    else
      step = a + d;
  endfunction

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    merge = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        merge[b*8 +: 8] = n[b*8 +: 8];
  endfunction

  // per-channel trigger decode, readiness and transfer path
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    logic [2:0] sel_own;
    logic       short_ev;
    logic       rx_dir;
    logic       en;
    logic [23:0] per_full;
    assign sel_own  = st_reg.ctrl[c][`CTL_SEL_HI:`CTL_SEL_LO];
    assign en       = st_reg.ctrl[c][`CTL_EN];
    assign per_full = {`PER_HIGH, st_reg.per[c]};
    assign rx_dir   = (sel_own == `SEL_RX_FULL);

    always_comb
    begin
      case (sel_own)
        3'h0, 3'h1, 3'h2, 3'h3: short_ev = timer_event_i[sel_own[1:0]];
        `SEL_TX_EMPTY:          short_ev = serial_tx_empty_i;
        `SEL_RX_FULL:           short_ev = serial_rx_full_i;
        `SEL_PIN_FALL:          short_ev = (c % 2 == 1) ? pin_fall[c/2] : 1'b0;
        default:                short_ev = 1'b0;
      endcase
    end

    if (c % 2 == 0)
    begin : g_a
      logic [2:0] sel_b;
      logic       full;
      logic       blk;
      logic       fev;
      logic       auto_go;
      logic       low_go;
      assign sel_b = st_reg.ctrl[c+1][`CTL_SEL_HI:`CTL_SEL_LO];
      assign full  = (st_reg.ctrl[c][`CTL_MODE_HI:`CTL_MODE_LO] == dma_act_pkg::MODE_FULL);
      assign blk   = st_reg.ctrl[c][`CTL_BLOCK];
      assign fev   = blk ? (sel_b[2] ? (sel_b == `SEL_PIN_FALL) & pin_fall[c/2]
                                     : timer_event_i[sel_b[1:0]])
                         : (sel_b == `SEL_PIN_FALL) & pin_fall[c/2];
      assign auto_go = full & ~blk & (sel_b == `SEL_AUTO_BURST | sel_b == `SEL_AUTO_STEAL);
      assign low_go  = full & ~blk & (sel_b == `SEL_PIN_LOW) & pin_low[c/2];
      assign ev[c]      = full ? fev : short_ev;
      assign burst[c]   = full & ~blk & (sel_b == `SEL_AUTO_BURST);
      assign is_full[c] = full;
      assign ready[c]   = full ? en & st_reg.ctrl[c+1][`CTL_EN] & (st_reg.pend[c] | auto_go | low_go)
                               : en & st_reg.pend[c];
      // two 24-bit addresses in full mode
      assign path_src[c] = (full | ~rx_dir) ? st_reg.mem[c] : per_full;
      assign path_dst[c] = full ? st_reg.mem[c+1] : (rx_dir ? st_reg.mem[c] : per_full);
    end
    else
    begin : g_b
      logic pair_full;
      assign pair_full  = (st_reg.ctrl[c-1][`CTL_MODE_HI:`CTL_MODE_LO] == dma_act_pkg::MODE_FULL);
      assign ev[c]      = ~pair_full & short_ev;
      assign burst[c]   = 1'b0;
      assign is_full[c] = 1'b0;
      assign ready[c]   = ~pair_full & en & st_reg.pend[c];
      assign path_src[c] = rx_dir ? per_full : st_reg.mem[c];
      assign path_dst[c] = rx_dir ? st_reg.mem[c] : per_full;
    end
  end

  // engine, pending flags and register slave
  always_comb
  begin
    logic [CW-1:0]  pick;
    logic [CW-1:0]  c;
    logic [CW-1:0]  cb;
    logic [15:0]    cnt_n;
    logic [CW-1:0]  wch;
    logic [31:0]    rd;
    logic [31:0]    wv;
    logic           full;
    logic           rep;
    pick  = '0;
    c     = st_reg.cur;
    cb    = {st_reg.cur[CW-1:1], 1'b1};
    cnt_n = st_reg.cnt[st_reg.cur] - 16'h0001;
    wch   = wb_adr_i[4 +: CW];
    rd    = 32'h00000000;
    wv    = 32'h00000000;
    full  = is_full[st_reg.cur];
    rep   = (st_reg.ctrl[st_reg.cur][`CTL_MODE_HI:`CTL_MODE_LO] == dma_act_pkg::MODE_REPEAT);
    st_next      = st_reg;
    st_next.done = '0;

    for (int i = NCH - 1; i >= 0; i--)
      if (ready[i])
        pick = CW'(i);

    case (st_reg.state)
      dma_act_pkg::ENG_IDLE:
      begin
        if (|ready)
        begin
          st_next.cur   = pick;
          st_next.state = dma_act_pkg::ENG_XFER;
          st_next.xreq  = 1'b1;
          st_next.src   = path_src[pick];
          st_next.dst   = path_dst[pick];
          st_next.word  = st_reg.ctrl[pick][`CTL_WORD];
        end
      end
      dma_act_pkg::ENG_XFER:
      begin
        if (xfer_ack_i)
        begin
          st_next.xreq    = 1'b0;
          st_next.pend[c] = 1'b0;
          st_next.cnt[c]  = cnt_n;
          if (full)
          begin
            st_next.mem[c]  = step(st_reg.mem[c], st_reg.ctrl[c], st_reg.word);
            st_next.mem[cb] = step(st_reg.mem[cb], st_reg.ctrl[cb], st_reg.word);
          end
          else if (st_reg.ctrl[c][`CTL_MODE_HI:`CTL_MODE_LO] != dma_act_pkg::MODE_IDLE)
            st_next.mem[c] = step(st_reg.mem[c], st_reg.ctrl[c], st_reg.word);
          if (cnt_n == 16'h0000)
          begin
            if (rep && !full)
            begin
              st_next.mem[c] = st_reg.mem_init[c];
              st_next.cnt[c] = st_reg.cnt_init[c];
            end
            else
            begin
              st_next.ctrl[c][`CTL_EN] = 1'b0;
              st_next.done[c] = st_reg.ctrl[c][`CTL_IRQ];
            end
          end
          if (burst[c] && cnt_n != 16'h0000)
            st_next.state = dma_act_pkg::ENG_NEXT;
          else
            st_next.state = dma_act_pkg::ENG_IDLE;
        end
      end
      dma_act_pkg::ENG_NEXT:
      begin
        if (ready[c])
        begin
          st_next.state = dma_act_pkg::ENG_XFER;
          st_next.xreq  = 1'b1;
          st_next.src   = path_src[c];
          st_next.dst   = path_dst[c];
        end
        else
          st_next.state = dma_act_pkg::ENG_IDLE;
      end
      default:
      begin
        st_next.state = dma_act_pkg::ENG_IDLE;
        st_next.xreq  = 1'b0;
      end
    endcase

    // set wins over clear, dropped while disabled
    for (int i = 0; i < NCH; i++)
      if (!st_reg.ctrl[i][`CTL_EN])
        st_next.pend[i] = 1'b0;
      else if (ev[i])
        st_next.pend[i] = 1'b1;

    // wishbone slave: one wait state, unmapped reads zero
    st_next.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !st_reg.ack)
    begin
      st_next.ack = 1'b1;
      if (wb_adr_i[7:4] < 4'(NCH))
      begin
        case (wb_adr_i[3:0])
          `OFS_CTRL: rd = {20'h00000, st_next.ctrl[wch]};
          `OFS_MEM:  rd = {8'h00, st_next.mem[wch]};
          `OFS_PER:  rd = {24'h000000, st_next.per[wch]};
          `OFS_CNT:  rd = {16'h0000, st_next.cnt[wch]};
          default:   rd = 32'h00000000;
        endcase
        wv = merge(rd, wb_dat_i, wb_sel_i);
        if (wb_we_i)
        begin
          case (wb_adr_i[3:0])
            `OFS_CTRL: st_next.ctrl[wch] = wv[11:0];
            `OFS_MEM:
            begin
              st_next.mem[wch]      = wv[23:0];
              st_next.mem_init[wch] = wv[23:0];
            end
            `OFS_PER:  st_next.per[wch] = wv[7:0];
            `OFS_CNT:
            begin
              st_next.cnt[wch]      = wv[15:0];
              st_next.cnt_init[wch] = wv[15:0];
            end
            default:   st_next.ack = 1'b1;
          endcase
        end
      end
      st_next.dat = rd;
    end
  end

  // single state register with clock enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg          <= '0;
      st_reg.ctrl     <= {NCH{`RST_CTRL}};
      st_reg.mem      <= {NCH{`RST_MEM}};
      st_reg.mem_init <= {NCH{`RST_MEM}};
      st_reg.per      <= {NCH{`RST_PER}};
      st_reg.cnt      <= {NCH{`RST_CNT}};
      st_reg.cnt_init <= {NCH{`RST_CNT}};
      st_reg.state    <= dma_act_pkg::ENG_IDLE;
    end
    else if (ce_i)
      st_reg <= st_next;
  end

  // outputs
  assign wb_ack_o    = st_reg.ack;
  assign wb_dat_o    = st_reg.dat;
  assign xfer_req_o  = st_reg.xreq;
  assign xfer_src_o  = st_reg.src;
  assign xfer_dst_o  = st_reg.dst;
  assign xfer_word_o = st_reg.word;
  assign end_pulse_o = st_reg.done;
  assign bus_lock_o  = burst[st_reg.cur] & (st_reg.state != dma_act_pkg::ENG_IDLE);

endmodule // dma_act_ctrl

/* File: test/xfer_bus_model.sv */
// far-side bus model answering the dma transfer request port
// assumes the requester holds req_i until it samples ack_o high
`timescale 1ns/1ps
module xfer_bus_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       req_i,
  input  wire logic [3:0] wait_i,
  output logic            ack_o
);
  logic [3:0] cnt_reg;

  // wait wait_i cycles on a held request, then a one-cycle ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o   <= 1'b0;
      cnt_reg <= 4'h0;
    end
    else
    begin
      ack_o <= 1'b0;
      if (req_i && !ack_o)
      begin
        if (cnt_reg == wait_i)
        begin
          ack_o   <= 1'b1;
          cnt_reg <= 4'h0;
        end
        else
        begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule // xfer_bus_model

/* File: test/dma_act_ctrl_assertions.sv */
// port-level checks of the dma activation block
// assumes ce_i high whenever a check matters
`timescale 1ns/1ps
module dma_act_ctrl_assertions #(
  parameter int NCH = 8
) (
  input wire logic           clk_i,
  input wire logic           rst_i,
  input wire logic           ce_i,
  input wire logic           wb_cyc_i,
  input wire logic           wb_stb_i,
  input wire logic           wb_we_i,
  input wire logic [7:0]     wb_adr_i,
  input wire logic [31:0]    wb_dat_o,
  input wire logic           wb_ack_o,
  input wire logic           xfer_req_o,
  input wire logic           xfer_ack_i,
  input wire logic [23:0]    xfer_src_o,
  input wire logic [23:0]    xfer_dst_o,
  input wire logic           xfer_word_o,
  input wire logic           bus_lock_o,
  input wire logic [NCH-1:0] end_pulse_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // register bus answer and transfer port handshake
  ack_cause_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o) else $error("ack missing");
  ack_pulse_a: assert property (
    wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack too long");
  unmapped_zero_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && ce_i && wb_adr_i[7:4] >= NCH
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  req_hold_a: assert property (
    xfer_req_o && !xfer_ack_i |=> xfer_req_o && $stable(xfer_src_o)
    && $stable(xfer_dst_o) && $stable(xfer_word_o)) else $error("request not held");
  req_drop_a: assert property (
    xfer_req_o && xfer_ack_i |=> !xfer_req_o) else $error("bus not released");
  req_fall_a: assert property (
    $fell(xfer_req_o) |-> $past(xfer_ack_i)) else $error("request dropped early");
  end_cause_a: assert property (
    end_pulse_o != '0 |-> $past(xfer_ack_i) && $onehot(end_pulse_o))
    else $error("end pulse without transfer");
  lock_run_a: assert property (
    $fell(xfer_req_o) && bus_lock_o |=> xfer_req_o || !bus_lock_o)
    else $error("burst gap too long");
  reset_quiet_a: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && !xfer_req_o && end_pulse_o == '0) else $error("busy in reset");

  // main scenarios
  cover property (xfer_req_o && xfer_ack_i && bus_lock_o);
  cover property (end_pulse_o != '0);
  cover property (wb_ack_o && wb_adr_i[7:4] >= NCH);
endmodule // dma_act_ctrl_assertions

bind dma_act_ctrl dma_act_ctrl_assertions #(.NCH(NCH)) chk_u (.clk_i, .rst_i, .ce_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .xfer_req_o,
  .xfer_ack_i, .xfer_src_o, .xfer_dst_o, .xfer_word_o, .bus_lock_o, .end_pulse_o);

/* File: test/test_dma_act_ctrl.sv */
// self-checking bench of the dma activation block
// assumes a 10 MHz clock and the bus model on the transfer port
`timescale 1ns/1ps
module test_dma_act_ctrl;
  logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, xfer_req_o, xfer_ack_i, xfer_word_o, bus_lock_o;
  logic [3:0]  timer_event_i = 4'h0, pin_n = 4'hf, wait_sel = 4'h0;
  logic        serial_tx_empty_i = 1'b0, serial_rx_full_i = 1'b0, lk;
  logic [23:0] xfer_src_o, xfer_dst_o, srcq[$], dstq[$];
  logic [7:0]  end_pulse_o, ends;
  int          errors = 0, check_count = 0;

  dma_act_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer_event_i(timer_event_i), .serial_tx_empty_i(serial_tx_empty_i),
    .serial_rx_full_i(serial_rx_full_i), .dma_request_pin_n_i(pin_n),
    .xfer_req_o(xfer_req_o), .xfer_ack_i(xfer_ack_i), .xfer_src_o(xfer_src_o),
    .xfer_dst_o(xfer_dst_o), .xfer_word_o(xfer_word_o), .bus_lock_o(bus_lock_o),
    .end_pulse_o(end_pulse_o));
  xfer_bus_model bus_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(xfer_req_o),
    .wait_i(wait_sel), .ack_o(xfer_ack_i));

  // 100 ns clock
  initial forever #50 clk_i = ~clk_i;

  // record every finished transfer, end pulses and bus lock
  always @(posedge clk_i)
  begin
    if (xfer_req_o === 1'b1 && xfer_ack_i === 1'b1)
    begin
      srcq.push_back(xfer_src_o);
      dstq.push_back(xfer_dst_o);
      lk = lk | bus_lock_o;
    end
    if (end_pulse_o !== 8'h00) ends = ends | end_pulse_o;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin errors++; stop_test(); end
  endtask

  // program one channel, control last so it starts once complete
  // only usable select codes
  task automatic setup(input logic [3:0] ch, input logic [31:0] c, m, p, n);
    wb(1'b1, {ch, 4'h4}, m); wb(1'b1, {ch, 4'h8}, p);
    wb(1'b1, {ch, 4'hc}, n); wb(1'b1, {ch, 4'h0}, c);
    ends = 8'h00; lk = 1'b0;
  endtask

  task automatic ev(input logic [3:0] t, input logic tx, input logic rx);
    timer_event_i <= t; serial_tx_empty_i <= tx; serial_rx_full_i <= rx;
    @(posedge clk_i);
    timer_event_i <= 4'h0; serial_tx_empty_i <= 1'b0; serial_rx_full_i <= 1'b0;
  endtask

  // wait for the next finished transfer and compare its addresses
  task automatic take(input logic [23:0] s, input logic [23:0] d);
    int n;
    n = 0;
    while (srcq.size() == 0 && n < 200) begin @(posedge clk_i); n++; end
    if (n >= 200) begin errors++; stop_test(); end
    check("src", 32'(srcq.pop_front()), 32'(s));
    check("dst", 32'(dstq.pop_front()), 32'(d));
  endtask

  task automatic t_regs();
    wb(1'b0, 8'h00, 0); check("ctrl reset", q, 32'h0);
    wb(1'b0, 8'h0c, 0); check("count reset", q, 32'h0);
    wb(1'b1, 8'hf0, 32'h5a); wb(1'b0, 8'hf0, 0); check("unmapped", q, 32'h0);
    $display("regs done");
  endtask

  task automatic t_io();
    setup(4'h0, 32'h098, 32'h001000, 32'h10, 32'h2);
    ev(4'h1, 1'b0, 1'b0); take(24'h001000, 24'hffff10);
    ev(4'h1, 1'b0, 1'b0); take(24'h001001, 24'hffff10);
    repeat (4) @(posedge clk_i);
    check("end", 32'(ends), 32'h01);
    check("byte", 32'(xfer_word_o), 32'h0);
    wb(1'b0, 8'h00, 0); check("enable", q & 32'h80, 32'h0);
    ev(4'h1, 1'b0, 1'b0); repeat (10) @(posedge clk_i);
    check("ignored", 32'(srcq.size()), 32'h0);
    $display("io done");
  endtask

  task automatic t_idle_rx();
    setup(4'h1, 32'h592, 32'h002000, 32'h20, 32'h2);
    ev(4'h0, 1'b0, 1'b1); take(24'hffff20, 24'h002000);
    ev(4'h0, 1'b0, 1'b1); take(24'hffff20, 24'h002000);
    repeat (4) @(posedge clk_i);
    check("no end", 32'(ends), 32'h0);
    $display("idle done");
  endtask

  task automatic t_repeat();
    setup(4'h2, 32'h49c, 32'h000200, 32'h33, 32'h1);
    ev(4'h0, 1'b1, 1'b0); take(24'h000200, 24'hffff33);
    ev(4'h0, 1'b1, 1'b0); take(24'h000200, 24'hffff33);
    repeat (4) @(posedge clk_i);
    check("wrap end", 32'(ends), 32'h0);
    wb(1'b1, 8'h20, 32'h0);
    $display("repeat done");
  endtask

  task automatic t_burst();
    setup(4'h0, 32'h0de, 32'h010000, 32'h0, 32'h3);
    setup(4'h1, 32'h090, 32'h020000, 32'h0, 32'h0);
    take(24'h010000, 24'h020000); take(24'h010002, 24'h020002);
    take(24'h010004, 24'h020004);
    repeat (4) @(posedge clk_i);
    check("lock", 32'(lk), 32'h1);
    check("word", 32'(xfer_word_o), 32'h1);
    check("end", 32'(ends != 8'h00), 32'h1);
    $display("burst done");
  endtask

  task automatic t_steal();
    wait_sel <= 4'h3;
    setup(4'h2, 32'h096, 32'h030000, 32'h0, 32'h2);
    setup(4'h3, 32'h290, 32'h040000, 32'h0, 32'h0);
    take(24'h030000, 24'h040000); take(24'h030001, 24'h040001);
    check("no lock", 32'(lk), 32'h0);
    wait_sel <= 4'h0;
    $display("steal done");
  endtask

  task automatic t_pin_block();
    setup(4'h6, 32'h087, 32'h050000, 32'h0, 32'h1);
    setup(4'h7, 32'h680, 32'h060000, 32'h0, 32'h0);
    pin_n <= 4'h7; repeat (6) @(posedge clk_i); pin_n <= 4'hf;
    take(24'h050000, 24'h060000);
    setup(4'h6, 32'h086, 32'h050000, 32'h0, 32'h2);
    setup(4'h7, 32'h780, 32'h060000, 32'h0, 32'h0);
    pin_n <= 4'h7;
    take(24'h050000, 24'h060000); take(24'h050000, 24'h060000);
    repeat (10) @(posedge clk_i);
    pin_n <= 4'hf;
    check("low stop", 32'(srcq.size()), 32'h0);
    $display("pin done");
  endtask

  // block mode timer trigger, decrementing source, frozen by clock enable
  task automatic t_freeze();
    setup(4'h0, 32'h0b7, 32'h0a0000, 32'h0, 32'h2);
    setup(4'h1, 32'h380, 32'h0b0000, 32'h0, 32'h0);
    ce_i <= 1'b0;
    ev(4'h8, 1'b0, 1'b0);
    repeat (6) @(posedge clk_i);
    check("frozen", 32'(srcq.size()), 32'h0);
    ce_i <= 1'b1;
    ev(4'h8, 1'b0, 1'b0); take(24'h0a0000, 24'h0b0000);
    ev(4'h8, 1'b0, 1'b0); take(24'h09ffff, 24'h0b0000);
    $display("freeze done");
  endtask

  task automatic t_prio();
    setup(4'h4, 32'h280, 32'h070000, 32'h44, 32'h1);
    setup(4'h5, 32'h280, 32'h080000, 32'h55, 32'h1);
    ev(4'h4, 1'b0, 1'b0);
    take(24'h070000, 24'hffff44); take(24'h080000, 24'hffff55);
    $display("priority done");
  endtask

  // reset, then every scenario in turn
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs(); t_io(); t_idle_rx(); t_repeat();
    t_burst(); t_steal(); t_pin_block(); t_prio(); t_freeze();
    stop_test();
  end
endmodule // test_dma_act_ctrl
